// ===== rtl/spd_page_decoder.sv
// Register space page decoder with page select register
`timescale 1ns/100ps
module spd_page_decoder (
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                acc_valid,
    input  wire logic [7:0]          acc_addr,
    input  wire logic                acc_direct,
    input  wire logic                acc_write,
    input  wire logic                acc_bit,
    input  wire logic [7:0]          acc_wdata,
    output logic                     dec_valid,
    output spd_pkg::spd_target_t     dec_target,
    output logic [6:0]               dec_index,
    output logic                     dec_page_f,
    output logic                     dec_hit,
    output logic                     dec_bit_ok,
    output logic                     dec_write,
    output logic [7:0]               page_select_reg
);
    import spd_pkg::*;

    // Everything the decoder remembers, registered as one bank
    typedef struct packed {
        logic        valid;
        spd_target_t target;
        logic [6:0]  index;
        logic        page_f;
        logic        hit;
        logic        bit_ok;
        logic        write;
        logic [7:0]  page;
    } spd_state_t;

    // Page in force, reduced to what the class table can tell apart
    typedef enum logic [1:0] {
        SPD_PG_ZERO  = 2'h0,
        SPD_PG_F     = 2'h1,
        SPD_PG_OTHER = 2'h2
    } spd_page_kind_t;

    // Decoder state and class lookup
    spd_state_t     st_reg;
    spd_state_t     st_next;
    spd_cls_if      lk ();
    spd_class_t     cls_now;
    spd_page_kind_t page_kind;
    spd_target_t    route_now;

    // Per-request decode terms
    logic           is_direct;
    logic           in_upper;
    logic           in_special;
    logic           bit_col;
    logic           bit_refused;
    logic           page_hit;
    logic           page_wr;

    // Class table, fed straight from the request address
    spd_class_rom spd_class_rom_i (
        .lk (lk)
    );

    // Route of a request: register space, data RAM or nothing
    function automatic spd_target_t spd_route(
        input logic valid,
        input logic direct,
        input logic upper
    );
        spd_target_t r;
        r = SPD_TGT_NONE;
        // Selector is {valid, direct, upper}
        case ({valid, direct, upper})
            3'h7: begin
                // Direct upper half only; the RAM behind it is unreachable
                r = SPD_TGT_SPECIAL;
            end
            3'h5: begin
                // Indirect upper half is physically separate RAM
                r = SPD_TGT_RAM;
            end
            3'h4, 3'h6: begin
                // Lower half is RAM in either addressing mode
                r = SPD_TGT_RAM;
            end
            default: begin
                r = SPD_TGT_NONE;
            end
        endcase
        return r;
    endfunction : spd_route

    // Sort the page value; unknown pages fall to the shared set
    function automatic spd_page_kind_t spd_page_kind(
        input logic [7:0] page
    );
        spd_page_kind_t k;
        k = SPD_PG_OTHER;
        case (page)
            SPD_PAGE_ZERO: begin
                k = SPD_PG_ZERO;
            end
            SPD_PAGE_F: begin
                k = SPD_PG_F;
            end
            default: begin
                // Any other page reaches only shared registers
                k = SPD_PG_OTHER;
            end
        endcase
        return k;
    endfunction : spd_page_kind

    // Presence of a register of class c on page kind k
    function automatic logic spd_class_hit(
        input spd_class_t     c,
        input spd_page_kind_t k
    );
        logic h;
        h = 1'b0;
        case (c)
            SPD_CL_ALL: begin
                h = 1'b1;
            end
            SPD_CL_P0: begin
                h = (k == SPD_PG_ZERO);
            end
            SPD_CL_PF: begin
                h = (k == SPD_PG_F);
            end
            SPD_CL_SPLIT: begin
                h = (k != SPD_PG_OTHER);
            end
            default: begin
                // Reserved hole; no register answers
                h = 1'b0;
            end
        endcase
        return h;
    endfunction : spd_class_hit

    // Bit access only on column 0 or 8 of a row
    function automatic logic spd_bit_col(
        input logic [7:0] addr
    );
        logic b;
        b = (addr[2:0] == SPD_BIT_LOW_MASK);
        return b;
    endfunction : spd_bit_col

    // Class lookup on the raw low address bits, every cycle
    assign lk.idx  = acc_addr[6:0];
    assign cls_now = lk.cls;

    // Page held before this edge; a write lands for the next request
    assign page_kind = spd_page_kind(st_reg.page);

    // Address space of the request
    assign is_direct  = acc_valid && acc_direct;
    assign in_upper   = (acc_addr >= SPD_DIRECT_BASE);
    assign in_special = is_direct && in_upper;
    assign route_now  = spd_route(acc_valid, acc_direct, in_upper);

    // Bit column test, and refusal of a bit access anywhere else
    assign bit_col     = in_special && spd_bit_col(acc_addr);
    assign bit_refused = acc_valid && acc_bit && !bit_col;

    // Register present on the page in force
    assign page_hit = in_special && !bit_refused &&
                      spd_class_hit(cls_now, page_kind);

    // Page select write from any page; bit form writes the whole byte
    assign page_wr = in_special && acc_write &&
                     (acc_addr == SPD_PAGE_ADDR);

    // Next state: one decoded access per request
    always_comb begin
        st_next        = st_reg;
        // Request fields echo through
        st_next.valid  = acc_valid;
        st_next.write  = acc_valid && acc_write;
        st_next.index  = acc_addr[6:0];
        // Decode result
        st_next.page_f = (page_kind == SPD_PG_F);
        st_next.target = route_now;
        st_next.hit    = page_hit;
        st_next.bit_ok = bit_col;
        if (page_wr) begin
            // No wait state: the very next request sees it
            st_next.page = acc_wdata;
        end
    end

    // State register; reset puts every access on page 0
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{
                valid:  1'b0,
                target: SPD_TGT_NONE,
                index:  7'h00,
                page_f: 1'b0,
                hit:    1'b0,
                bit_ok: 1'b0,
                write:  1'b0,
                page:   SPD_PAGE_RESET
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign dec_valid       = st_reg.valid;
    assign dec_target      = st_reg.target;
    assign dec_index       = st_reg.index;
    assign dec_page_f      = st_reg.page_f;
    assign dec_hit         = st_reg.hit;
    assign dec_bit_ok      = st_reg.bit_ok;
    assign dec_write       = st_reg.write;
    assign page_select_reg = st_reg.page;
endmodule : spd_page_decoder

// ===== rtl/spd_pkg.sv
// Constants and types for the register page decoder
package spd_pkg;
    localparam logic [7:0] SPD_DIRECT_BASE  = 8'h80;
    localparam logic [7:0] SPD_PAGE_ADDR    = 8'hA7;
    localparam logic [7:0] SPD_PAGE_RESET   = 8'h00;
    localparam logic [7:0] SPD_PAGE_ZERO    = 8'h00;
    localparam logic [7:0] SPD_PAGE_F       = 8'h0F;
    localparam logic [2:0] SPD_BIT_LOW_MASK = 3'h0;
    localparam int         SPD_NUM_ADDR     = 128;

    // Decode class of each address: 0 unmapped, 1 page 0 only,
    // 2 page F only, 3 every page, 4 page 0 and separate page F entry
    typedef enum logic [2:0] {
        SPD_CL_NONE  = 3'b000,
        SPD_CL_P0    = 3'b001,
        SPD_CL_PF    = 3'b010,
        SPD_CL_ALL   = 3'b011,
        SPD_CL_SPLIT = 3'b100
    } spd_class_t;

    typedef enum logic [1:0] {
        SPD_TGT_NONE = 2'b00,
        SPD_TGT_SPECIAL = 2'b01,
        SPD_TGT_RAM  = 2'b10
    } spd_target_t;
endpackage : spd_pkg

// ===== rtl/spd_cls_if.sv
// Interface carrying an address lookup between top and class table
`timescale 1ns/100ps
interface spd_cls_if;
    logic [6:0]          idx;
    spd_pkg::spd_class_t cls;
    modport req (output idx, input cls);
    modport rsp (input idx, output cls);
endinterface : spd_cls_if

// ===== rtl/spd_class_rom.sv
// Address class table for the two register pages
`timescale 1ns/100ps
module spd_class_rom (
    spd_cls_if.rsp lk
);
    import spd_pkg::*;

    // Index is the address minus 0x80; unlisted entries are page 0 only
    function automatic spd_class_t spd_lookup(input logic [6:0] i);
        spd_class_t c;
        c = SPD_CL_P0;
        case (i)
            // Shared on all pages
            7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
            7'h10, 7'h1A, 7'h1C, 7'h1E, 7'h20, 7'h27, 7'h28, 7'h29,
            7'h39, 7'h3B, 7'h3C, 7'h50, 7'h60, 7'h65, 7'h66, 7'h67,
            7'h70, 7'h76, 7'h77:
                c = SPD_CL_ALL;
            // Page 0 register and a distinct page F register
            7'h0D, 7'h0E, 7'h19, 7'h1B, 7'h1D, 7'h35, 7'h5E, 7'h62,
            7'h63, 7'h73:
                c = SPD_CL_SPLIT;
            // Unoccupied address
            7'h34:
                c = SPD_CL_NONE;
            default:
                c = SPD_CL_P0;
        endcase
        return c;
    endfunction : spd_lookup

    assign lk.cls = spd_lookup(lk.idx);
endmodule : spd_class_rom

// ===== sim/spd_cpu_model.sv
// Core-side model issuing register space accesses
`timescale 1ns/100ps
module spd_cpu_model (
    input  wire logic clk_sys,
    output logic       acc_valid,
    output logic [7:0] acc_addr,
    output logic       acc_direct,
    output logic       acc_write,
    output logic       acc_bit,
    output logic [7:0] acc_wdata
);
    initial {acc_valid, acc_addr, acc_direct, acc_write, acc_bit} = '0;
    initial acc_wdata = 8'h00;
    // One request per edge; returns just after the answering edge
    task acc(input logic [7:0] a, input logic d, w, b, input logic [7:0] wd);
        {acc_valid, acc_addr, acc_direct} = {1'b1, a, d};
        {acc_write, acc_bit, acc_wdata} = {w, b, wd};
        @(posedge clk_sys);
        #1;
    endtask : acc
    // Address and write data flip so stale values cannot pass for valid ones
    task idle();
        acc_valid = 1'b0;
        acc_addr  = ~acc_addr;
        acc_wdata = ~acc_wdata;
        @(posedge clk_sys);
        #1;
    endtask : idle
endmodule : spd_cpu_model

// ===== sim/spd_page_decoder_props.sv
// Concurrent checks on the page decoder ports
`timescale 1ns/100ps
module spd_page_decoder_props (
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    input wire logic                 acc_valid,
    input wire logic                 acc_direct,
    input wire logic                 acc_write,
    input wire logic                 acc_bit,
    input wire logic [7:0]           acc_addr,
    input wire logic [7:0]           acc_wdata,
    input wire logic                 dec_valid,
    input wire spd_pkg::spd_target_t dec_target,
    input wire logic [6:0]           dec_index,
    input wire logic                 dec_page_f,
    input wire logic                 dec_hit,
    input wire logic                 dec_bit_ok,
    input wire logic                 dec_write,
    input wire logic [7:0]           page_select_reg
);
    import spd_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Helper terms keep the properties short
    wire logic dr = acc_valid & acc_direct;
    wire logic pg = dr & (acc_addr == SPD_PAGE_ADDR);
    wire logic lo = acc_addr[2:0] == 3'h0;
    wire logic [6:0] ix = acc_addr[6:0];
    sequence s_pw; pg && acc_write && !acc_bit; endsequence
    property p_special;
        dr && acc_addr[7] |=> dec_target == SPD_TGT_SPECIAL;
    endproperty
    a_special: assert property (p_special) else $error("direct route");
    property p_ram;
        acc_valid && !acc_direct && acc_addr[7] |=> dec_target == SPD_TGT_RAM;
    endproperty
    a_ram: assert property (p_ram) else $error("indirect route");
    property p_bit; dr && acc_bit && !lo |=> !dec_hit; endproperty
    a_bit: assert property (p_bit) else $error("bit refuse");
    property p_bitok; dr && acc_addr[7] |=> dec_bit_ok == $past(lo); endproperty
    a_bitok: assert property (p_bitok) else $error("bit column");
    property p_pgw; s_pw |=> page_select_reg == $past(acc_wdata); endproperty
    a_pgw: assert property (p_pgw) else $error("page write");
    property p_hold; !(pg && acc_write) |=> $stable(page_select_reg); endproperty
    a_hold: assert property (p_hold) else $error("page hold");
    property p_pagef;
        dec_valid |-> dec_page_f == ($past(page_select_reg) == SPD_PAGE_F);
    endproperty
    a_pagef: assert property (p_pagef) else $error("page steer");
    property p_shared; pg && !acc_bit |=> dec_hit; endproperty
    a_shared: assert property (p_shared) else $error("shared");
    // Every request comes back one edge later with its own fields
    property p_echo;
        acc_valid |=> dec_valid && dec_write == $past(acc_write) &&
                      dec_index == $past(ix);
    endproperty
    a_echo: assert property (p_echo) else $error("request echo");
endmodule : spd_page_decoder_props
bind spd_page_decoder spd_page_decoder_props spd_page_decoder_props_i (.*);

// ===== sim/spd_page_decoder_tb.sv
// Self-checking bench for the page decoder
`timescale 1ns/100ps
module spd_page_decoder_tb;
    import spd_pkg::*;
    logic        clk_sys, rstn, acc_valid, acc_direct, acc_write, acc_bit;
    logic        dec_valid, dec_page_f, dec_hit, dec_bit_ok, dec_write;
    logic [7:0]  acc_addr, acc_wdata, page_select_reg;
    logic [6:0]  dec_index;
    spd_target_t dec_target;
    int          err_count = 0, compares = 0, cyc = 0;
    spd_page_decoder spd_page_decoder_i (.*);
    spd_cpu_model    spd_cpu_model_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the few dozen cycles needed
    always @(posedge clk_sys) if (++cyc == 2000) begin
        err_count++;
        end_of_test();
    end
    task chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Mode bits: direct, write, bit
    task ac(input logic [7:0] a, input logic [2:0] m, input logic [7:0] d);
        spd_cpu_model_i.acc(a, m[2], m[1], m[0], d);
    endtask : ac
    task t_route();
        chk("page", page_select_reg, 8'h00);
        ac(8'h88, 3'h5, 8'h00);
        chk("target", dec_target, SPD_TGT_SPECIAL);
        chk("bit_ok", dec_bit_ok, 1'b1);
        ac(8'h88, 3'h0, 8'h00);
        chk("target", dec_target, SPD_TGT_RAM);
        ac(8'h89, 3'h5, 8'h00);
        chk("hit", dec_hit, 1'b0);
        ac(8'hB4, 3'h4, 8'h00);
        chk("hit", dec_hit, 1'b0);
        spd_cpu_model_i.idle();
        $display("t_route done");
    endtask : t_route
    // Page switch to 0xF and back to 0, each seen by the very next request
    task t_page();
        ac(8'hA7, 3'h6, 8'h0F);
        ac(8'h88, 3'h4, 8'h00);
        chk("page", page_select_reg, 8'h0F);
        chk("hit", dec_hit, 1'b0);
        chk("page_f", dec_page_f, 1'b1);
        ac(8'hA7, 3'h4, 8'h00);
        chk("hit", dec_hit, 1'b1);
        ac(8'hA7, 3'h6, 8'h00);
        ac(8'hDE, 3'h4, 8'h00);
        chk("page_f", dec_page_f, 1'b0);
        chk("hit", dec_hit, 1'b1);
        spd_cpu_model_i.idle();
        $display("t_page done");
    endtask : t_page
    // Odd page reaches shared only; split entry seen on page 0xF
    task t_other();
        ac(8'hA7, 3'h6, 8'h01);
        chk("write", dec_write, 1'b1);
        chk("page", page_select_reg, 8'h01);
        ac(8'h88, 3'h4, 8'h00);
        chk("write", dec_write, 1'b0);
        chk("hit", dec_hit, 1'b0);
        ac(8'h80, 3'h5, 8'h00);
        chk("hit", dec_hit, 1'b1);
        ac(8'hA7, 3'h6, 8'h0F);
        ac(8'h8D, 3'h4, 8'h00);
        chk("hit", dec_hit, 1'b1);
        chk("page_f", dec_page_f, 1'b1);
        chk("index", dec_index, 7'h0D);
        chk("valid", dec_valid, 1'b1);
        spd_cpu_model_i.idle();
        chk("valid", dec_valid, 1'b0);
        chk("target", dec_target, SPD_TGT_NONE);
        $display("t_other done");
    endtask : t_other
    // Reset in mid-run while page 0xF is set
    task t_reset();
        rstn = 1'b0;
        spd_cpu_model_i.idle();
        chk("page", page_select_reg, 8'h00);
        chk("valid", dec_valid, 1'b0);
        rstn = 1'b1;
        ac(8'h8D, 3'h4, 8'h00);
        chk("page_f", dec_page_f, 1'b0);
        chk("hit", dec_hit, 1'b1);
        chk("index", dec_index, 7'h0D);
        spd_cpu_model_i.idle();
        $display("t_reset done");
    endtask : t_reset
    initial begin
        rstn = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 rstn = 1'b1;
        t_route();
        t_page();
        t_other();
        t_reset();
        end_of_test();
    end
endmodule : spd_page_decoder_tb
